// ===== hdl/switch_table_pkg.sv
package switch_table_pkg;

    // register indices as numbered on the switch register map; byte address is four times the index
    localparam logic [15:0] IDX_LOOKUP_CMD_STATUS = 16'h1808;
    localparam logic [15:0] IDX_LOOKUP_CONFIG     = 16'h1809;
    localparam logic [15:0] IDX_VLAN_CMD          = 16'h180B;
    localparam logic [15:0] IDX_VLAN_WR_DATA      = 16'h180C;
    localparam logic [15:0] IDX_VLAN_CMD_STATUS   = 16'h180D;
    localparam logic [15:0] IDX_VLAN_RD_DATA      = 16'h180E;

    localparam logic [17:0] ADDR_LOOKUP_CMD_STATUS = {IDX_LOOKUP_CMD_STATUS, 2'h0};
    localparam logic [17:0] ADDR_LOOKUP_CONFIG     = {IDX_LOOKUP_CONFIG, 2'h0};
    localparam logic [17:0] ADDR_VLAN_CMD          = {IDX_VLAN_CMD, 2'h0};
    localparam logic [17:0] ADDR_VLAN_WR_DATA      = {IDX_VLAN_WR_DATA, 2'h0};
    localparam logic [17:0] ADDR_VLAN_CMD_STATUS   = {IDX_VLAN_CMD_STATUS, 2'h0};
    localparam logic [17:0] ADDR_VLAN_RD_DATA      = {IDX_VLAN_RD_DATA, 2'h0};

    // field positions
    localparam int MAKE_PENDING_BIT  = 0;
    localparam int INIT_COMPLETE_BIT = 1;
    localparam int AGING_TEST_BIT    = 0;
    localparam int OP_PENDING_BIT    = 0;
    localparam int CMD_DIRECTION_BIT = 5;
    localparam int CMD_TABLE_SEL_BIT = 4;
    localparam int CMD_INDEX_MSB     = 3;
    localparam int ENTRY_MSB         = 17;
    localparam int VLAN_ID_MSB       = 11;
    localparam int VLAN_UNTAG_LSB    = 12;
    localparam int VLAN_MEMBER_LSB   = 13;
    localparam int PVID_PRIO_LSB     = 12;
    localparam int PVID_PRIO_MSB     = 14;

    // reset values
    localparam logic        AGING_TEST_RST = 1'h0;
    localparam logic [5:0]  VLAN_CMD_RST   = 6'h00;
    localparam logic [17:0] ENTRY_RST      = 18'h00000;

    // table sizes
    localparam int VLAN_ENTRIES = 16;
    localparam int PORT_COUNT   = 3;

    // timing: pclk period and the figures they derive from
    localparam longint CLK_HZ         = 20_000_000;
    localparam int     CLK_NS         = 50;
    localparam int     INIT_NS        = 20_000;
    localparam int     INIT_CYCLES    = (INIT_NS + CLK_NS - 1) / CLK_NS;
    localparam longint AGE_NORMAL_S   = 300;
    localparam longint AGE_FAST_MS    = 50;
    localparam longint AGE_NORMAL_CYC = AGE_NORMAL_S * CLK_HZ;
    localparam longint AGE_FAST_CYC   = AGE_FAST_MS * CLK_HZ / 1000;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_REQ,
        ACC_WAIT
    } access_state_t;

    typedef struct packed {
        logic [8:0]    init_cnt;
        logic          init_done;
        logic          make_pend;
        logic          age_test;
        logic [32:0]   age_cnt;
        logic          age_tick;
        logic          cmd_rnw;
        logic          cmd_tsel;
        logic [3:0]    cmd_idx;
        logic [17:0]   wr_data;
        logic [17:0]   rd_data;
        logic          launch;
        access_state_t state;
        logic [31:0]   prdata;
        logic          pslverr;
    } ctrl_state_t;

    typedef struct packed {
        logic [VLAN_ENTRIES-1:0][17:0] vlan;
        logic [PORT_COUNT-1:0][17:0]   pvid;
        logic                          ack;
        logic [17:0]                   rdata;
    } table_state_t;

endpackage

// ===== hdl/vlan_table_store.sv
`timescale 1ns/100ps
module vlan_table_store
    import switch_table_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        acc_req,
    input  wire logic        acc_rnw,
    input  wire logic        acc_tsel,
    input  wire logic [3:0]  acc_idx,
    input  wire logic [17:0] acc_wdata,
    output logic             acc_ack,
    output logic [17:0]      acc_rdata,
    input  wire logic [11:0] lookup_vid,
    output logic             lookup_hit,
    output logic [2:0]       lookup_member,
    output logic [2:0]       lookup_untag,
    input  wire logic [1:0]  pvid_port,
    output logic [17:0]      pvid_entry
);
    table_state_t                s_reg;
    table_state_t                s_next;
    logic [VLAN_ENTRIES-1:0]     hit_vec;
    logic [17:0]                 hit_entry;

    // one access per request; answer registered one cycle later
    always_comb begin
        s_next     = s_reg;
        s_next.ack = acc_req;
        if (acc_req) begin
            if (acc_rnw) begin
                if (acc_tsel) begin
                    // ports 3..15 do not exist; such a read returns zero
                    s_next.rdata = (acc_idx < 4'(PORT_COUNT)) ? s_reg.pvid[acc_idx[1:0]] : ENTRY_RST;
                end else begin
                    s_next.rdata = s_reg.vlan[acc_idx];
                end
            end else if (acc_tsel) begin
                if (acc_idx < 4'(PORT_COUNT)) begin
                    s_next.pvid[acc_idx[1:0]] = acc_wdata;
                end
            end else begin
                s_next.vlan[acc_idx] = acc_wdata;
            end
        end
    end

    // tables clear at reset, so every entry starts disabled by a zero identifier
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // per-entry match; a zero identifier never matches
    for (genvar g = 0; g < VLAN_ENTRIES; g++) begin : g_match
        assign hit_vec[g] = (s_reg.vlan[g][VLAN_ID_MSB:0] != 12'h000) &&
                            (s_reg.vlan[g][VLAN_ID_MSB:0] == lookup_vid);
    end

    // lowest matching entry wins if software loads a duplicate identifier
    always_comb begin
        hit_entry = ENTRY_RST;
        for (int i = VLAN_ENTRIES - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                hit_entry = s_reg.vlan[i];
            end
        end
    end

    for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
        assign lookup_member[p] = hit_entry[VLAN_MEMBER_LSB + 2 * p];
        assign lookup_untag[p]  = hit_entry[VLAN_UNTAG_LSB + 2 * p];
    end

    assign lookup_hit = |hit_vec;
    assign acc_ack    = s_reg.ack;
    assign acc_rdata  = s_reg.rdata;
    assign pvid_entry = (pvid_port < 2'(PORT_COUNT)) ? s_reg.pvid[pvid_port] : ENTRY_RST;
endmodule

// ===== hdl/switch_table_access_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - lookup table initialisation starts automatically after every switch fabric reset.
// - initialisation lasts about twenty microseconds, here 400 clock cycles.
// - every received packet is dropped while initialisation runs.
// - init-complete status bit 1 reads 0 after reset, sets when initialisation ends.
// - status bit 0 shows a make-entry command running; clears itself; resets 0.
// - age-test bit 0 shortens aging period from five minutes to fifty milliseconds.
// - each write to the VLAN command register launches the described table access; here a second write before a queued one starts replaces it.
// - reads complete when operation-pending clears; then read data may be taken.
// - writes need write data loaded first; operation-pending shows completion.
// - command bit 5 chooses read (1) or write (0); resets 0.
// - command bit 4 chooses port default table (1) or VLAN table (0).
// - command bits 3:0 index VLAN 0-15 or port 0-2; software keeps range.
// - write data holds 18 bits; bits 31:18 reserved and read as zero.
// - VLAN entry bit 17 makes port 2 a member for ingress and broadcast.
// - non-member ports filter ingress unless admitted, and leave egress broadcast.
// - untag bits strip tags on egress for hybrid ports; bit 16 for port 2.
// - entry bits 11:0 hold the VLAN identifier; zero disables the entry.
module switch_table_access_regs
    import switch_table_pkg::*;
#(
    parameter logic [32:0] AGE_NORMAL_CYCLES = 33'(AGE_NORMAL_CYC),
    parameter logic [32:0] AGE_FAST_CYCLES   = 33'(AGE_FAST_CYC)
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        make_start,
    input  wire logic        make_done,
    output logic             lookup_init_busy,
    output logic             rx_drop_all,
    output logic             aging_tick,
    input  wire logic [11:0] lookup_vid,
    input  wire logic [1:0]  rx_port,
    input  wire logic [2:0]  admit_non_member,
    input  wire logic [2:0]  hybrid_port,
    output logic             vlan_ingress_filter,
    output logic [2:0]       egress_member_mask,
    output logic [2:0]       egress_untag_mask,
    output logic [11:0]      rx_default_vid,
    output logic [2:0]       rx_default_prio
);
    ctrl_state_t s_reg;
    ctrl_state_t s_next;
    logic        setup_phase;
    logic        access_phase;
    logic        addr_mapped;
    logic        op_pending;
    logic        acc_req;
    logic        acc_ack;
    logic [17:0] acc_rdata;
    logic        lookup_hit;
    logic [2:0]  lookup_member;
    logic [2:0]  lookup_untag;
    logic [17:0] pvid_entry;
    logic [32:0] age_limit;

    // zero-wait slave: every access phase completes in its first cycle
    assign pready       = 1'b1;
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign op_pending   = s_reg.launch || (s_reg.state != ACC_IDLE);
    assign acc_req      = (s_reg.state == ACC_REQ);
    assign age_limit    = s_reg.age_test ? AGE_FAST_CYCLES : AGE_NORMAL_CYCLES;

    // address decode shared by setup and access phases
    always_comb begin
        unique case (paddr)
            ADDR_LOOKUP_CMD_STATUS,
            ADDR_LOOKUP_CONFIG,
            ADDR_VLAN_CMD,
            ADDR_VLAN_WR_DATA,
            ADDR_VLAN_CMD_STATUS,
            ADDR_VLAN_RD_DATA:    addr_mapped = 1'b1;
            default:              addr_mapped = 1'b0;
        endcase
    end

    always_comb begin
        s_next          = s_reg;
        s_next.age_tick = 1'b0;

        // lookup table clear after reset; the counter stops once done
        if (!s_reg.init_done) begin
            s_next.init_cnt = s_reg.init_cnt + 9'h001;
            if (s_reg.init_cnt == 9'(INIT_CYCLES - 1)) begin
                s_next.init_done = 1'b1;
            end
        end

        // make-entry tracking; a start in the done cycle keeps the bit set
        if (make_done) begin
            s_next.make_pend = 1'b0;
        end
        if (make_start) begin
            s_next.make_pend = 1'b1;
        end

        // aging period; >= guards against the limit shrinking under a running count
        if (s_reg.age_cnt >= age_limit - 33'h000000001) begin
            s_next.age_cnt  = '0;
            s_next.age_tick = 1'b1;
        end else begin
            s_next.age_cnt = s_reg.age_cnt + 33'h000000001;
        end

        // read data is prepared in setup so it stands through the access phase
        if (setup_phase) begin
            s_next.pslverr = !addr_mapped;
            s_next.prdata  = 32'h00000000;
            if (!pwrite) begin
                unique case (paddr)
                    ADDR_LOOKUP_CMD_STATUS: begin
                        s_next.prdata[INIT_COMPLETE_BIT] = s_reg.init_done;
                        s_next.prdata[MAKE_PENDING_BIT]  = s_reg.make_pend;
                    end
                    ADDR_LOOKUP_CONFIG:   s_next.prdata[AGING_TEST_BIT] = s_reg.age_test;
                    ADDR_VLAN_CMD:        s_next.prdata[5:0] = {s_reg.cmd_rnw, s_reg.cmd_tsel, s_reg.cmd_idx};
                    ADDR_VLAN_WR_DATA:    s_next.prdata[ENTRY_MSB:0] = s_reg.wr_data;
                    ADDR_VLAN_CMD_STATUS: s_next.prdata[OP_PENDING_BIT] = op_pending;
                    ADDR_VLAN_RD_DATA:    s_next.prdata[ENTRY_MSB:0] = s_reg.rd_data;
                    default:              s_next.prdata = 32'h00000000;
                endcase
            end
        end

        // table access sequencer; a command written mid-access is queued, but a second write before it starts replaces it
        unique case (s_reg.state)
            ACC_IDLE: begin
                if (s_reg.launch) begin
                    s_next.launch = 1'b0;
                    s_next.state  = ACC_REQ;
                end
            end
            ACC_REQ:  s_next.state = ACC_WAIT;
            ACC_WAIT: begin
                if (acc_ack) begin
                    if (s_reg.cmd_rnw) begin
                        s_next.rd_data = acc_rdata;
                    end
                    s_next.state = ACC_IDLE;
                end
            end
        endcase

        // writes land at the access edge; unmapped addresses change nothing
        if (access_phase && pwrite) begin
            unique case (paddr)
                ADDR_LOOKUP_CONFIG: s_next.age_test = pwdata[AGING_TEST_BIT];
                ADDR_VLAN_CMD: begin
                    s_next.cmd_rnw  = pwdata[CMD_DIRECTION_BIT];
                    s_next.cmd_tsel = pwdata[CMD_TABLE_SEL_BIT];
                    s_next.cmd_idx  = pwdata[CMD_INDEX_MSB:0];
                    s_next.launch   = 1'b1;
                end
                ADDR_VLAN_WR_DATA:  s_next.wr_data = pwdata[ENTRY_MSB:0];
                default:            s_next.wr_data = s_next.wr_data;
            endcase
        end
    end

    // one register for all control state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg          <= '0;
            s_reg.age_test <= AGING_TEST_RST;
            s_reg.cmd_rnw  <= VLAN_CMD_RST[CMD_DIRECTION_BIT];
            s_reg.cmd_tsel <= VLAN_CMD_RST[CMD_TABLE_SEL_BIT];
            s_reg.cmd_idx  <= VLAN_CMD_RST[CMD_INDEX_MSB:0];
            s_reg.wr_data  <= ENTRY_RST;
            s_reg.state    <= ACC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    vlan_table_store u_store (
        .pclk          (pclk),
        .presetn       (presetn),
        .acc_req       (acc_req),
        .acc_rnw       (s_reg.cmd_rnw),
        .acc_tsel      (s_reg.cmd_tsel),
        .acc_idx       (s_reg.cmd_idx),
        .acc_wdata     (s_reg.wr_data),
        .acc_ack       (acc_ack),
        .acc_rdata     (acc_rdata),
        .lookup_vid    (lookup_vid),
        .lookup_hit    (lookup_hit),
        .lookup_member (lookup_member),
        .lookup_untag  (lookup_untag),
        .pvid_port     (rx_port),
        .pvid_entry    (pvid_entry)
    );

    assign prdata           = s_reg.prdata;
    assign pslverr          = s_reg.pslverr;
    assign lookup_init_busy = !s_reg.init_done;
    assign rx_drop_all      = !s_reg.init_done;
    assign aging_tick       = s_reg.age_tick;

    // a miss leaves the packet alone; only a matching entry can filter it
    assign vlan_ingress_filter = lookup_hit && !lookup_member[rx_port] && !admit_non_member[rx_port];
    assign egress_member_mask  = lookup_hit ? lookup_member : 3'h0;
    assign egress_untag_mask   = lookup_hit ? (lookup_untag & hybrid_port) : 3'h0;
    assign rx_default_vid      = pvid_entry[VLAN_ID_MSB:0];
    assign rx_default_prio     = pvid_entry[PVID_PRIO_MSB:PVID_PRIO_LSB];

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property init_length_p;
        $rose(s_reg.init_done) |-> $past(s_reg.init_cnt) == 9'(INIT_CYCLES - 1);
    endproperty
    init_length_a: assert property (init_length_p) else $error("init ended at wrong count");

    init_drop_a: assert property (!s_reg.init_done |-> rx_drop_all && lookup_init_busy)
        else $error("packets not dropped during init");

    init_sticky_a: assert property (s_reg.init_done |=> s_reg.init_done)
        else $error("init complete fell without reset");

    make_set_a: assert property (make_start |=> s_reg.make_pend)
        else $error("make pending not set");

    make_clear_a: assert property (make_done && !make_start |=> !s_reg.make_pend)
        else $error("make pending not cleared");

    age_fast_a: assert property (aging_tick && $past(s_reg.age_test) && $past(s_reg.age_test, 2) |->
            $past(s_reg.age_cnt) >= AGE_FAST_CYCLES - 33'h000000001)
        else $error("fast aging tick too early");

    cmd_launch_a: assert property (access_phase && pwrite && paddr == ADDR_VLAN_CMD |=>
            op_pending ##1 op_pending)
        else $error("command write did not raise pending");

    access_done_a: assert property (acc_req |=> acc_ack ##1 (s_reg.state == ACC_IDLE))
        else $error("table access did not finish in two cycles");

    rd_capture_a: assert property (s_reg.state == ACC_WAIT && acc_ack && s_reg.cmd_rnw |=>
            s_reg.rd_data == $past(acc_rdata))
        else $error("read data not captured");

    wr_reserved_a: assert property (setup_phase && !pwrite && paddr == ADDR_VLAN_WR_DATA |=>
            prdata[31:18] == 14'h0000 && prdata[17:0] == $past(s_reg.wr_data))
        else $error("write data readback wrong");

    unmapped_err_a: assert property (setup_phase && !addr_mapped |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    // register fields land at the access edge
    cmd_fields_a: assert property (access_phase && pwrite && paddr == ADDR_VLAN_CMD |=>
            s_reg.cmd_rnw == $past(pwdata[CMD_DIRECTION_BIT]) &&
            s_reg.cmd_tsel == $past(pwdata[CMD_TABLE_SEL_BIT]) &&
            s_reg.cmd_idx == $past(pwdata[CMD_INDEX_MSB:0]))
        else $error("command fields not stored");

    age_cfg_a: assert property (access_phase && pwrite && paddr == ADDR_LOOKUP_CONFIG |=>
            s_reg.age_test == $past(pwdata[AGING_TEST_BIT]))
        else $error("age test bit not stored");

    wr_data_a: assert property (access_phase && pwrite && paddr == ADDR_VLAN_WR_DATA |=>
            s_reg.wr_data == $past(pwdata[ENTRY_MSB:0]))
        else $error("write data not stored");

    unmapped_wr_a: assert property (access_phase && pwrite && !addr_mapped |=>
            s_reg.wr_data == $past(s_reg.wr_data) && s_reg.age_test == $past(s_reg.age_test))
        else $error("unmapped write changed a register");

    // status bits follow their events
    status_read_a: assert property (setup_phase && !pwrite && paddr == ADDR_LOOKUP_CMD_STATUS |=>
            prdata == {30'h0000000, $past(s_reg.init_done), $past(s_reg.make_pend)})
        else $error("lookup status readback wrong");

    make_hold_a: assert property (!make_start && !make_done |=> s_reg.make_pend == $past(s_reg.make_pend))
        else $error("make pending changed without event");

    init_count_a: assert property (!s_reg.init_done |-> s_reg.init_cnt < 9'(INIT_CYCLES))
        else $error("init counter ran past its end");

    tick_pulse_a: assert property (aging_tick |=> !aging_tick)
        else $error("aging tick longer than one cycle");

    // table access sequencing; a queued command keeps pending high, so it is excluded
    pending_clear_a: assert property (s_reg.state == ACC_WAIT && !s_reg.launch &&
            !(access_phase && pwrite && paddr == ADDR_VLAN_CMD) |=> !op_pending)
        else $error("pending did not clear after access");

    rd_hold_a: assert property (s_reg.state != ACC_WAIT |=> s_reg.rd_data == $past(s_reg.rd_data))
        else $error("read data changed outside an access");

    cmd_write_c:  cover property (access_phase && pwrite && paddr == ADDR_VLAN_CMD);
    rd_done_c:    cover property (s_reg.state == ACC_WAIT && acc_ack && s_reg.cmd_rnw);
    init_done_c:  cover property ($rose(s_reg.init_done));
    queued_cmd_c: cover property (s_reg.state != ACC_IDLE && s_reg.launch);
    fast_tick_c:  cover property (aging_tick && s_reg.age_test);
endmodule

// ===== sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    import switch_table_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, tmp;
    logic        make_start, make_done, lookup_init_busy, rx_drop_all, aging_tick, filt;
    logic [11:0] lookup_vid, dvid;
    logic [1:0]  rx_port;
    logic [2:0]  admit_non_member, hybrid_port, mmask, umask, dprio;
    int          failures, total_checks, n, cyc;
    time         t0;

    // short aging periods keep the run brief
    switch_table_access_regs #(.AGE_NORMAL_CYCLES(33'h28), .AGE_FAST_CYCLES(33'hA)) u_switch_table_access_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .make_start(make_start), .make_done(make_done), .lookup_init_busy(lookup_init_busy),
        .rx_drop_all(rx_drop_all), .aging_tick(aging_tick), .lookup_vid(lookup_vid), .rx_port(rx_port),
        .admit_non_member(admit_non_member), .hybrid_port(hybrid_port), .vlan_ingress_filter(filt),
        .egress_member_mask(mmask), .egress_untag_mask(umask), .rx_default_vid(dvid),
        .rx_default_prio(dprio));

    // 50 ns period
    always #25 pclk = ~pclk;

    task print_verdict;
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task hang;
        failures++;
        print_verdict();
    endtask

    // one apb transfer; an idle edge follows so the next setup never overwrites the release
    task xfer(input logic wr, input logic [17:0] a, input logic [31:0] wd, output logic [31:0] rdat);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) hang();
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [17:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, tmp);
    endtask

    task rd_chk(input logic [17:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, tmp);
        check(tmp, exp);
    endtask

    // launch a table access and poll until pending drops
    task run_cmd(input logic [31:0] cmd);
        wr(ADDR_VLAN_CMD, cmd);
        rd_chk(ADDR_VLAN_CMD_STATUS, 32'h1);
        n = 0;
        do begin
            xfer(1'b0, ADDR_VLAN_CMD_STATUS, 32'h0, tmp);
            n++;
        end while (tmp[0] !== 1'b0 && n < 20);
        if (tmp[0] !== 1'b0) hang();
        rd_chk(ADDR_VLAN_CMD, cmd);
    endtask

    // drive the packet-side inputs, then compare the lookup outputs
    task look(input logic [11:0] v, input logic [1:0] p, input logic [2:0] adm, input logic [2:0] hyb,
              input logic f, input logic [2:0] m, input logic [2:0] u);
        lookup_vid <= v;
        rx_port <= p;
        admit_non_member <= adm;
        hybrid_port <= hyb;
        @(posedge pclk);
        @(posedge pclk);
        check(32'(filt), 32'(f));
        check(32'(mmask), 32'(m));
        check(32'(umask), 32'(u));
    endtask

    // cycles between two aging pulses
    task age_period(output int p);
        p = 0;
        do begin
            @(posedge pclk);
            p++;
        end while (aging_tick !== 1'b1 && p < 200);
        if (aging_tick !== 1'b1) hang();
        p = 0;
        do begin
            @(posedge pclk);
            p++;
        end while (aging_tick !== 1'b1 && p < 200);
        if (aging_tick !== 1'b1) hang();
    endtask

    // wait for the table clear to end; gives the cycles since the release at t0
    task wait_init(output int c);
        n = 0;
        while (lookup_init_busy !== 1'b0 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        if (lookup_init_busy !== 1'b0) hang();
        c = int'(($time - t0) / CLK_NS);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0;
        pwdata = 32'h0;
        make_start = 1'b0;
        make_done = 1'b0;
        lookup_vid = 12'h0;
        rx_port = 2'h0;
        admit_non_member = 3'h0;
        hybrid_port = 3'h0;
        failures = 0;
        total_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t0 = $time;
        @(posedge pclk);
        check(32'(rx_drop_all), 32'h1);
        rd_chk(ADDR_LOOKUP_CMD_STATUS, 32'h0);
        rd_chk(ADDR_LOOKUP_CONFIG, 32'h0);
        rd_chk(ADDR_VLAN_CMD, 32'h0);
        rd_chk(ADDR_VLAN_WR_DATA, 32'h0);
        // unmapped place answers with an error and zero data
        xfer(1'b0, 18'h00000, 32'h0, tmp);
        check(tmp, 32'h0);
        check(32'(pslverr), 32'h1);
        // an unmapped write is refused and changes nothing
        xfer(1'b1, 18'h00004, 32'hFFFFFFFF, tmp);
        check(32'(pslverr), 32'h1);
        rd_chk(ADDR_LOOKUP_CONFIG, 32'h0);
        rd_chk(ADDR_VLAN_WR_DATA, 32'h0);
        // wait for table initialisation before touching anything lookup related
        wait_init(cyc);
        check(32'(cyc >= 399 && cyc <= 401), 32'h1);
        check(32'(rx_drop_all), 32'h0);
        rd_chk(ADDR_LOOKUP_CMD_STATUS, 32'h2);
        // make-entry pending follows its start and done pulses
        make_start <= 1'b1;
        @(posedge pclk);
        make_start <= 1'b0;
        rd_chk(ADDR_LOOKUP_CMD_STATUS, 32'h3);
        make_done <= 1'b1;
        @(posedge pclk);
        make_done <= 1'b0;
        rd_chk(ADDR_LOOKUP_CMD_STATUS, 32'h2);
        // aging period, normal then shortened
        age_period(cyc);
        check(32'(cyc), 32'd40);
        wr(ADDR_LOOKUP_CONFIG, 32'hFFFFFFFF);
        rd_chk(ADDR_LOOKUP_CONFIG, 32'h1);
        age_period(cyc);
        check(32'(cyc), 32'd10);
        // reserved data bits are dropped
        wr(ADDR_VLAN_WR_DATA, 32'hFFFFFFFF);
        rd_chk(ADDR_VLAN_WR_DATA, 32'h0003FFFF);
        // two vlan entries written, then read back, high and low member fields
        wr(ADDR_VLAN_WR_DATA, 32'h00038123);
        run_cmd(32'h05);
        wr(ADDR_VLAN_WR_DATA, 32'h00007456);
        run_cmd(32'h00);
        run_cmd(32'h25);
        rd_chk(ADDR_VLAN_RD_DATA, 32'h00038123);
        run_cmd(32'h20);
        rd_chk(ADDR_VLAN_RD_DATA, 32'h00007456);
        look(12'h123, 2'h0, 3'h0, 3'h7, 1'b1, 3'h6, 3'h4);
        look(12'h123, 2'h0, 3'h1, 3'h7, 1'b0, 3'h6, 3'h4);
        look(12'h456, 2'h1, 3'h0, 3'h1, 1'b1, 3'h1, 3'h1);
        look(12'h000, 2'h0, 3'h0, 3'h7, 1'b0, 3'h0, 3'h0);
        // port default entry for port 2: priority 5, identifier 0AB
        wr(ADDR_VLAN_WR_DATA, 32'h000050AB);
        run_cmd(32'h12);
        run_cmd(32'h32);
        rd_chk(ADDR_VLAN_RD_DATA, 32'h000050AB);
        rx_port <= 2'h2;
        @(posedge pclk);
        @(posedge pclk);
        check({17'h0, dprio, dvid}, 32'h000050AB);
        // a second reset mid-run restarts the table clear and restores defaults
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t0 = $time;
        @(posedge pclk);
        check(32'(lookup_init_busy), 32'h1);
        rd_chk(ADDR_LOOKUP_CMD_STATUS, 32'h0);
        rd_chk(ADDR_LOOKUP_CONFIG, 32'h0);
        look(12'h123, 2'h0, 3'h0, 3'h7, 1'b0, 3'h0, 3'h0);
        wait_init(cyc);
        check(32'(cyc >= 399 && cyc <= 401), 32'h1);
        print_verdict();
    end
endmodule
